// *** design/ccpmd_pin_decode.sv ***
// Combinational decode of control pins into an operating mode
`timescale 1ns/100ps
module ccpmd_pin_decode
  import ccpmd_pkg::*;
(
  input  wire logic        ext_control_enable_n,     // Dedicated enable, low = extended
  input  wire logic        clk_reset_style_select,   // High = single-ended reset
  input  wire ccpmd_tri_t  full_scale_range_select,  // Resolved shared pin level
  input  wire logic        output_clock_reset_pos,   // Reset true input
  input  wire logic        calibration_delay_select, // Cal delay / serial select pin
  output ccpmd_mode_t      mode                      // Decoded mode
);

  logic single_ended;
  logic alternate_ext_control_enable;
  logic shared_as_neg;

  // Reset style and role of the shared pin
  assign single_ended                 = clk_reset_style_select;
  assign alternate_ext_control_enable = single_ended & full_scale_range_select.mid;
  assign shared_as_neg                = ~single_ended & full_scale_range_select.high;

  // Dedicated enable alone decides, overriding the shared pin
  assign mode.ext_active   = ~ext_control_enable_n;
  assign mode.alt_override = alternate_ext_control_enable & ext_control_enable_n;
  assign mode.diff_reset   = ~single_ended;

  // Pin full scale: single-ended low pin gives reduced range, otherwise higher
  assign mode.fs_high     = ~single_ended | ~full_scale_range_select.low;
  assign mode.fs_reg_ctrl = ~ext_control_enable_n;

  // Cal delay pin turns into serial chip select under extended control
  assign mode.cal_delay_long  = ext_control_enable_n & calibration_delay_select;
  assign mode.serial_select_n = ext_control_enable_n | calibration_delay_select;

  // Differential reset asserts when true is high and complement low
  assign mode.clk_reset = single_ended ? output_clock_reset_pos
                                       : (output_clock_reset_pos & ~shared_as_neg);

endmodule : ccpmd_pin_decode

// *** design/ccpmd_pkg.sv ***
// Package: register map, field layout and mode carrier for control pin mode decode
package ccpmd_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] CCPMD_FSADJ_OFS  = 8'h00;
  localparam logic [7:0] CCPMD_STATUS_OFS = 8'h04;

  // Full-scale adjust register layout and reset value
  localparam int         CCPMD_FSADJ_W    = 8;
  localparam logic [7:0] CCPMD_FSADJ_RST  = 8'h80;

  // Status register bit positions
  localparam int CCPMD_ST_EXT_ACTIVE   = 0;
  localparam int CCPMD_ST_DIFF_RESET   = 1;
  localparam int CCPMD_ST_FS_HIGH      = 2;
  localparam int CCPMD_ST_FS_REG_CTRL  = 3;
  localparam int CCPMD_ST_CAL_DLY_LONG = 4;
  localparam int CCPMD_ST_ALT_OVERRIDE = 5;
  localparam int CCPMD_ST_CAL_ACTIVE   = 6;

  // Reset values of the decoded mode outputs
  localparam logic CCPMD_EXT_ACTIVE_RST = 1'b0;
  localparam logic CCPMD_DIFF_RST       = 1'b0;
  localparam logic CCPMD_FS_HIGH_RST    = 1'b1;
  localparam logic CCPMD_SSEL_N_RST     = 1'b1;

  // Resolved level of the three-level shared pin
  typedef struct packed {
    logic low;                          // Driven low
    logic high;                         // Driven high
    logic mid;                          // Floating or mid-supply
  } ccpmd_tri_t;

  // Decoded operating mode
  typedef struct packed {
    logic ext_active;                   // Extended control in force
    logic diff_reset;                   // Differential clock reset
    logic fs_high;                      // Higher full-scale range
    logic fs_reg_ctrl;                  // Full scale from register
    logic cal_delay_long;               // Long power-up cal delay
    logic serial_select_n;              // Serial chip select, active low
    logic alt_override;                 // Shared-pin request overridden
    logic clk_reset;                    // Resolved output clock reset
  } ccpmd_mode_t;

  // APB access phases
  typedef enum logic [1:0] {
    CCPMD_IDLE,
    CCPMD_SETUP,
    CCPMD_ACCESS
  } ccpmd_apb_phase_t;

endpackage : ccpmd_pkg

// *** design/ccpmd_top.sv ***
// Control pin mode decode with APB status and full-scale adjust registers
// Overview of operation
// - The calibration active flag is high for the whole calibration sequence and low otherwise.
// - A high dedicated extended-control enable keeps extended control off and configuration from pins only.
// - The dedicated enable wins over the shared-pin alternate enable whenever they disagree.
// - Clock-reset style select high or floating means single-ended reset and a full-scale/enable shared pin.
// - Clock-reset style select low means a differential reset pair, shared pin as the complement.
// - In differential reset mode pin full-scale selection is ignored and the higher range is used.
// - While the dedicated enable is low, the full-scale adjust register may be written in either style.
// - In single-ended mode a low shared pin picks reduced range, high picks higher, mid asks extended control.
// - Under extended control the cal delay pin is serial chip select and the cal delay is short.
//
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
module ccpmd_top
  import ccpmd_pkg::*;
(
  input  wire logic        clk,                      // 10 MHz converter clock
  input  wire logic        reset,                    // Asynchronous reset, active high
  // Control pins
  input  wire logic        ext_control_enable_n,     // Dedicated enable, low = extended
  input  wire logic        clk_reset_style_select,   // High/floating = single-ended
  input  wire ccpmd_tri_t  full_scale_range_select,  // Shared pin resolved level
  input  wire logic        output_clock_reset_pos,   // Clock reset true input
  input  wire logic        calibration_delay_select, // Cal delay / serial select pin
  input  wire logic        cal_sequence_busy,        // Calibration engine running
  // Decoded outputs
  output logic             calibration_active_flag,  // High while calibrating
  output logic             ext_mode_active,          // Extended control in force
  output logic             diff_reset_mode,          // Differential clock reset
  output logic             output_clock_reset,       // Resolved clock reset
  output logic             fs_range_high,            // Higher full-scale range
  output logic             fs_reg_control,           // Full scale from register
  output logic [7:0]       fs_adjust,                // Full-scale adjust code
  output logic             cal_delay_long,           // Long power-up cal delay
  output logic             serial_select_n,          // Serial chip select, active low
  // APB slave
  input  wire logic        psel,                     // Slave select
  input  wire logic        penable,                  // Access phase
  input  wire logic        pwrite,                   // Write when high
  input  wire logic [7:0]  paddr,                    // Byte address
  input  wire logic [31:0] pwdata,                   // Write data
  output logic [31:0]      prdata,                   // Read data
  output logic             pready,                   // Always ready
  output logic             pslverr                   // Error answer
);

  ccpmd_mode_t          mode_nxt;
  ccpmd_mode_t          mode_r;
  logic                 cal_active_r;
  logic [7:0]           fsadj_r;
  logic [7:0]           fsadj_nxt;
  logic [31:0]          prdata_r;
  logic [31:0]          prdata_nxt;
  logic                 err_r;
  logic                 err_nxt;
  ccpmd_apb_phase_t     phase;
  logic                 setup_cycle;
  logic                 access_cycle;
  logic                 hit_fsadj;
  logic                 hit_status;
  logic                 fsadj_wr;
  logic                 wr_refused;
  logic [31:0]          status_word;

  // Pure combinational pin decode
  ccpmd_pin_decode ccpmd_pin_decode_inst (
    .ext_control_enable_n     (ext_control_enable_n),
    .clk_reset_style_select   (clk_reset_style_select),
    .full_scale_range_select  (full_scale_range_select),
    .output_clock_reset_pos   (output_clock_reset_pos),
    .calibration_delay_select (calibration_delay_select),
    .mode                     (mode_nxt)
  );

  // Mode outputs registered once per clock
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r.ext_active      <= CCPMD_EXT_ACTIVE_RST;
      mode_r.diff_reset      <= CCPMD_DIFF_RST;
      mode_r.fs_high         <= CCPMD_FS_HIGH_RST;
      mode_r.fs_reg_ctrl     <= CCPMD_EXT_ACTIVE_RST;
      mode_r.cal_delay_long  <= 1'b0;
      mode_r.serial_select_n <= CCPMD_SSEL_N_RST;
      mode_r.alt_override    <= 1'b0;
      mode_r.clk_reset       <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Calibration running indication
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cal_active_r <= 1'b0;
    end else begin
      cal_active_r <= cal_sequence_busy;
    end
  end

  // APB phase tracking, used for the read, write and error paths
  always_comb begin
    unique case ({psel, penable})
      2'b10:   phase = CCPMD_SETUP;
      2'b11:   phase = CCPMD_ACCESS;
      default: phase = CCPMD_IDLE;
    endcase
  end

  // Address decode and write qualification
  assign setup_cycle  = (phase == CCPMD_SETUP);
  assign access_cycle = (phase == CCPMD_ACCESS);
  assign hit_fsadj    = (paddr == CCPMD_FSADJ_OFS);
  assign hit_status   = (paddr == CCPMD_STATUS_OFS);
  assign fsadj_wr     = access_cycle & pwrite & hit_fsadj & mode_r.ext_active;
  assign wr_refused   = pwrite & ((hit_fsadj & ~mode_r.ext_active) | hit_status);
  assign fsadj_nxt    = fsadj_wr ? pwdata[CCPMD_FSADJ_W-1:0] : fsadj_r;

  // Full-scale adjust register, writable only under extended control
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fsadj_r <= CCPMD_FSADJ_RST;
    end else begin
      fsadj_r <= fsadj_nxt;
    end
  end

  // Status word built from the live mode state
  always_comb begin
    status_word                        = 32'h0000_0000;
    status_word[CCPMD_ST_EXT_ACTIVE]   = mode_r.ext_active;
    status_word[CCPMD_ST_DIFF_RESET]   = mode_r.diff_reset;
    status_word[CCPMD_ST_FS_HIGH]      = mode_r.fs_high;
    status_word[CCPMD_ST_FS_REG_CTRL]  = mode_r.fs_reg_ctrl;
    status_word[CCPMD_ST_CAL_DLY_LONG] = mode_r.cal_delay_long;
    status_word[CCPMD_ST_ALT_OVERRIDE] = mode_r.alt_override;
    status_word[CCPMD_ST_CAL_ACTIVE]   = cal_active_r;
  end

  // Read data and address error captured in the setup cycle
  assign prdata_nxt = (setup_cycle & ~pwrite & hit_fsadj)  ? {24'h00_0000, fsadj_r} :
                      (setup_cycle & ~pwrite & hit_status) ? status_word :
                      setup_cycle                          ? 32'h0000_0000 : prdata_r;
  assign err_nxt    = setup_cycle ? (~hit_fsadj & ~hit_status) : err_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // Output drive
  assign calibration_active_flag = cal_active_r;
  assign ext_mode_active         = mode_r.ext_active;
  assign diff_reset_mode         = mode_r.diff_reset;
  assign output_clock_reset      = mode_r.clk_reset;
  assign fs_range_high           = mode_r.fs_high;
  assign fs_reg_control          = mode_r.fs_reg_ctrl;
  assign fs_adjust               = fsadj_r;
  assign cal_delay_long          = mode_r.cal_delay_long;
  assign serial_select_n         = mode_r.serial_select_n;
  assign prdata                  = prdata_r;
  assign pready                  = 1'b1;
  assign pslverr                 = access_cycle & (err_r | wr_refused);

  // Named sequences for multi-step checks
  sequence s_refused_write;
    psel && penable && pwrite && (paddr == CCPMD_FSADJ_OFS) && !mode_r.ext_active;
  endsequence

  sequence s_granted_write;
    psel && penable && pwrite && (paddr == CCPMD_FSADJ_OFS) && mode_r.ext_active;
  endsequence

  sequence s_diff_pulse;
    !clk_reset_style_select && output_clock_reset_pos && !full_scale_range_select.high;
  endsequence

  property p_cal_flag;
    @(posedge clk) disable iff (reset)
      ##1 calibration_active_flag == $past(cal_sequence_busy);
  endproperty
  a_cal_flag: assert property (p_cal_flag) else $error("Calibration flag not tracking busy");

  property p_pins_only;
    @(posedge clk) disable iff (reset)
      ext_control_enable_n |=> !ext_mode_active && !fs_reg_control && serial_select_n;
  endproperty
  a_pins_only: assert property (p_pins_only) else $error("Extended mode while enable high");

  property p_ext_on;
    @(posedge clk) disable iff (reset)
      !ext_control_enable_n |=> ext_mode_active && fs_reg_control;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("Extended mode missing while enable low");

  property p_dedicated_wins;
    @(posedge clk) disable iff (reset)
      (clk_reset_style_select && full_scale_range_select.mid && ext_control_enable_n)
        |=> !ext_mode_active ##1 $past(mode_r.alt_override);
  endproperty
  a_dedicated_wins: assert property (p_dedicated_wins) else $error("Shared pin beat enable");

  property p_se_reset;
    @(posedge clk) disable iff (reset)
      clk_reset_style_select |=> !diff_reset_mode && (output_clock_reset == $past(output_clock_reset_pos));
  endproperty
  a_se_reset: assert property (p_se_reset) else $error("Single-ended reset not followed");

  property p_diff_reset;
    @(posedge clk) disable iff (reset)
      s_diff_pulse |=> diff_reset_mode && output_clock_reset;
  endproperty
  a_diff_reset: assert property (p_diff_reset) else $error("Differential reset not taken");

  property p_diff_fs_high;
    @(posedge clk) disable iff (reset)
      (!clk_reset_style_select && full_scale_range_select.low) |=> fs_range_high;
  endproperty
  a_diff_fs_high: assert property (p_diff_fs_high) else $error("Pin range used in differential mode");

  property p_fsadj_locked;
    @(posedge clk) disable iff (reset)
      s_refused_write |=> $stable(fs_adjust);
  endproperty
  a_fsadj_locked: assert property (p_fsadj_locked) else $error("Adjust written without extended mode");

  property p_fsadj_written;
    @(posedge clk) disable iff (reset)
      s_granted_write |=> fs_adjust == $past(pwdata[7:0]);
  endproperty
  a_fsadj_written: assert property (p_fsadj_written) else $error("Adjust write lost");

  property p_se_range;
    @(posedge clk) disable iff (reset)
      (clk_reset_style_select && full_scale_range_select.low) |=> !fs_range_high;
  endproperty
  a_se_range: assert property (p_se_range) else $error("Low shared pin did not reduce range");

  property p_serial_select;
    @(posedge clk) disable iff (reset)
      !ext_control_enable_n |=> !cal_delay_long && (serial_select_n == $past(calibration_delay_select));
  endproperty
  a_serial_select: assert property (p_serial_select) else $error("Cal delay pin not serial select");

  // Further decode and bus checks
  sequence s_alt_request;
    clk_reset_style_select && full_scale_range_select.mid;
  endsequence

  property p_alt_flag;
    @(posedge clk) disable iff (reset)
      s_alt_request |=> mode_r.alt_override == $past(ext_control_enable_n);
  endproperty
  a_alt_flag: assert property (p_alt_flag) else $error("Override flag wrong");

  property p_se_range_high;
    @(posedge clk) disable iff (reset)
      (clk_reset_style_select && full_scale_range_select.high) |=> fs_range_high;
  endproperty
  a_se_range_high: assert property (p_se_range_high) else $error("High shared pin not higher range");

  property p_mid_range;
    @(posedge clk) disable iff (reset)
      s_alt_request |=> fs_range_high;
  endproperty
  a_mid_range: assert property (p_mid_range) else $error("Mid shared pin changed the range");

  property p_cal_delay_pin;
    @(posedge clk) disable iff (reset)
      ext_control_enable_n |=> cal_delay_long == $past(calibration_delay_select);
  endproperty
  a_cal_delay_pin: assert property (p_cal_delay_pin) else $error("Cal delay pin not followed");

  property p_diff_blocked;
    @(posedge clk) disable iff (reset)
      (!clk_reset_style_select && full_scale_range_select.high) |=> diff_reset_mode && !output_clock_reset;
  endproperty
  a_diff_blocked: assert property (p_diff_blocked) else $error("Reset taken with complement high");

  property p_refused_err;
    @(posedge clk) disable iff (reset)
      s_refused_write |-> pslverr;
  endproperty
  a_refused_err: assert property (p_refused_err) else $error("Refused adjust write not flagged");

  property p_granted_ok;
    @(posedge clk) disable iff (reset)
      s_granted_write |-> !pslverr;
  endproperty
  a_granted_ok: assert property (p_granted_ok) else $error("Granted adjust write flagged");

  property p_cal_low;
    @(posedge clk) disable iff (reset)
      !cal_sequence_busy |=> !calibration_active_flag;
  endproperty
  a_cal_low: assert property (p_cal_low) else $error("Calibration flag high while idle");

endmodule : ccpmd_top

// *** dv/ccpmd_board_model.sv ***
// Board strap model that drives the converter control pins
`timescale 1ns/100ps
module ccpmd_board_model
  import ccpmd_pkg::*;
(
  input  wire logic [6:0] strap,                     // Requested straps from the bench
  output logic            ext_control_enable_n,      // Dedicated enable pin
  output logic            clk_reset_style_select,    // Reset style pin
  output ccpmd_tri_t      full_scale_range_select,   // Shared pin, resolved level
  output logic            output_clock_reset_pos,    // Clock reset true input
  output logic            calibration_delay_select,  // Cal delay pin
  output logic            cal_sequence_busy          // Calibration engine running
);
  // Plain straps follow the bench request
  assign ext_control_enable_n     = strap[6];
  assign clk_reset_style_select   = strap[5];
  assign output_clock_reset_pos   = strap[2];
  assign calibration_delay_select = strap[1];
  assign cal_sequence_busy        = strap[0];
  // Shared pin resolved to exactly one level; codes 2 and 3 float it
  assign full_scale_range_select.low  = (strap[4:3] == 2'h0);
  assign full_scale_range_select.high = (strap[4:3] == 2'h1);
  assign full_scale_range_select.mid  = strap[4];
endmodule : ccpmd_board_model

// *** dv/ccpmd_top_tb.sv ***
// Self-checking bench for the control pin mode decode
`timescale 1ns/100ps
module ccpmd_top_tb;
  import ccpmd_pkg::*;
  typedef struct {int due; logic [15:0] val;} ccpmd_note_t;
  logic clk, reset, psel, penable, pwrite;
  logic [6:0] strap;
  logic [7:0] paddr, fs_exp;
  logic [31:0] pwdata, prdata, w;
  logic en_n, sel, pos, cdly, busy, pready, pslverr;
  logic cal_f, ext_a, diff_m, ocr, fsh, fsreg, cal_l, ssel_n;
  logic [7:0] fs_adjust;
  logic [15:0] mode_seen;
  ccpmd_tri_t shared;
  ccpmd_note_t q_mode[$];
  ccpmd_note_t nt;
  logic [33:0] q_bus[$];
  logic [33:0] bn;
  int cyc, seed, mismatches, checks_done, i;

  ccpmd_board_model ccpmd_board_model_inst (.strap(strap), .ext_control_enable_n(en_n),
    .clk_reset_style_select(sel), .full_scale_range_select(shared), .output_clock_reset_pos(pos),
    .calibration_delay_select(cdly), .cal_sequence_busy(busy));
  ccpmd_top ccpmd_top_inst (.clk(clk), .reset(reset), .ext_control_enable_n(en_n),
    .clk_reset_style_select(sel), .full_scale_range_select(shared), .output_clock_reset_pos(pos),
    .calibration_delay_select(cdly), .cal_sequence_busy(busy), .calibration_active_flag(cal_f),
    .ext_mode_active(ext_a), .diff_reset_mode(diff_m), .output_clock_reset(ocr), .fs_range_high(fsh),
    .fs_reg_control(fsreg), .fs_adjust(fs_adjust), .cal_delay_long(cal_l), .serial_select_n(ssel_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Expected decoded outputs from the straps
  function automatic logic [7:0] mode_exp(input logic [6:0] s);
    return {s[0], !s[6], !s[5], s[5] ? s[2] : (s[2] & (s[4:3] != 2'h1)),
            !s[5] | (s[4:3] != 2'h0), !s[6], s[6] & s[1], s[6] | s[1]};
  endfunction : mode_exp

  // Expected status word
  function automatic logic [31:0] status_exp(input logic [6:0] s);
    logic [7:0] m;
    m = mode_exp(s);
    return {25'h0, m[7], s[6] & s[5] & s[4], m[1], m[2], m[3], m[5], m[6]};
  endfunction : status_exp

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Drive straps just after an edge and note the expected outputs
  task automatic drive(input logic [6:0] s);
    strap <= s;
    q_mode.push_back('{cyc + 2, {mode_exp(s), fs_exp}});
    repeat (2) @(posedge clk);
  endtask : drive

  // One APB transfer; the answer is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] er, input logic ee);
    q_bus.push_back({!wr, er, ee});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic give_verdict;
    $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Monitor: take the oldest note whenever a result is due
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (q_mode.size() > 0 && q_mode[0].due == cyc) begin
      nt = q_mode.pop_front();
      mode_seen = {cal_f, ext_a, diff_m, ocr, fsh, fsreg, cal_l, ssel_n, fs_adjust};
      chk("mode", {16'h0, nt.val}, {16'h0, mode_seen});
    end
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && q_bus.size() > 0) begin
      bn = q_bus.pop_front();
      chk("pslverr", {31'h0, bn[0]}, {31'h0, pslverr});
      if (bn[33]) chk("prdata", bn[32:1], prdata);
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(100 * 5000);
    mismatches++;
    give_verdict();
  end

  initial begin
    reset = 1'b1;
    strap = 7'h40;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cyc = 0;
    seed = 2803;
    fs_exp = CCPMD_FSADJ_RST;
    repeat (12) @(posedge clk);
    chk("reset", 32'h0000_0680, {21'h0, fsh, ssel_n, ext_a, fs_adjust});
    reset <= 1'b0;
    drive(7'h40);
    apb(1'b0, CCPMD_FSADJ_OFS, 32'h0, {24'h0, CCPMD_FSADJ_RST}, 1'b0);
    // Random straps across all modes
    for (i = 0; i < 200; i++) begin
      w = $random(seed);
      drive(w[6:0]);
    end
    // Shared pin requests extended control while dedicated enable is high
    drive(7'h70);
    apb(1'b0, CCPMD_STATUS_OFS, 32'h0, status_exp(7'h70), 1'b0);
    // Full-scale adjust writes in both reset styles
    for (i = 0; i < 2; i++) begin
      w = $random(seed);
      drive({1'b1, i[0], 5'h03});
      apb(1'b1, CCPMD_FSADJ_OFS, w, 32'h0, 1'b1);
      apb(1'b0, CCPMD_FSADJ_OFS, 32'h0, {24'h0, fs_exp}, 1'b0);
      drive({1'b0, i[0], 5'h03});
      apb(1'b1, CCPMD_FSADJ_OFS, w, 32'h0, 1'b0);
      fs_exp = w[7:0];
      apb(1'b0, CCPMD_FSADJ_OFS, 32'h0, {24'h0, fs_exp}, 1'b0);
      drive({1'b0, i[0], 5'h03});
    end
    // Status is read only and unmapped space answers with an error
    drive(7'h07);
    apb(1'b1, CCPMD_STATUS_OFS, 32'hFF, 32'h0, 1'b1);
    apb(1'b0, CCPMD_STATUS_OFS, 32'h0, status_exp(7'h07), 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h0, 1'b1);
    repeat (3) @(posedge clk);
    // Every noted result must have been compared
    chk("notes left", 32'h0, q_mode.size() + q_bus.size());
    give_verdict();
  end
endmodule : ccpmd_top_tb
